// *** logic/flash_program_protect_ctrl.sv ***
// Flash controller: commands, sector protection, programming, option load
// Functional notes
// - Protect bits can be set, never cleared
// - Command 5EH maps protect register at FF9H
// - Other command values restore page select access
// - Command 00H returns controller to reset state
// - Reset clears all sector protect bits
// - Protected sectors refuse program and erase
// - Programming needs unlock plus successful erase enable
// - Mass enables all bytes, page only selected
// - Erased reads FFH; programming only clears bits
// - Core stalls while programming; clock keeps running
// - Non-erase command exits programming and relocks
// - Debugger writes and constant stores both program
// - Option bytes copied before core leaves reset
// - Option changes apply only after next reset
// - Option registers invisible to software access
// - Options drive watchdog, protection, brown-out, oscillator
`include "flash_ctrl_map.svh"
module flash_program_protect_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int ERASE_CYCLES = `ERASE_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire prog_req_t cpu_req,
  output logic cpu_ready,
  input wire prog_req_t dbg_req,
  output logic dbg_ready,
  input wire logic [`FLASH_AW-1:0] fetch_addr,
  output logic [7:0] fetch_data,
  output logic cpu_stall,
  output logic cpu_hold,
  output opt_cfg_t opt_cfg
);

  fstate_t state_q;
  ldstate_t ld_q;
  logic prot_sel_q;
  logic [7:0] page_sel_q;
  logic [7:0] prot;
  logic busy_q;
  logic [`TIMER_W-1:0] timer_q;
  logic [7:0] rdata_q;
  logic hit_q;
  opt_cfg_t opt_q;
  logic loaded_q;
  logic [7:0] mem_rdata;
  logic [`FLASH_AW-1:0] mem_rd_addr;

  // Page index of a program address, used by the program checks
  function automatic logic [2:0] page_of(input logic [`FLASH_AW-1:0] a);
    page_of = a[`PAGE_MSB:`PAGE_LSB];
  endfunction

  // True when the page's protect bit is set
  function automatic logic page_locked(input logic [7:0] p,
                                       input logic [2:0] idx);
    page_locked = p[idx];
  endfunction

  // Bus write decode
  logic fctl_wr;
  logic fprot_wr;
  logic [7:0] cmd;
  assign fctl_wr = clk_en && reg_req.wr && (reg_req.addr == `FCTL_ADDR);
  assign fprot_wr = clk_en && reg_req.wr && (reg_req.addr == `FPROT_ADDR);
  assign cmd = reg_req.wdata;

  logic [2:0] sel_page;
  logic erase_ok;
  logic page_erase_go;
  logic mass_erase_go;
  logic unlocked;
  assign sel_page = page_sel_q[2:0];
  assign unlocked = (state_q == FS_UNLOCKED) || (state_q == FS_PAGE_EN) ||
                    (state_q == FS_MASS_EN);
  assign erase_ok = unlocked && !busy_q && !opt_q.prog_protect;
  assign page_erase_go = fctl_wr && (cmd == `CMD_PAGE_ERASE) && erase_ok &&
                         !page_locked(prot, sel_page);
  assign mass_erase_go = fctl_wr && (cmd == `CMD_MASS_ERASE) && erase_ok &&
                         (prot == `PROT_RESET);

  // Command state: unlock sequence, erase enables, relock on others
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= FS_LOCKED;
    end else if (fctl_wr) begin
      if (page_erase_go) begin
        state_q <= FS_PAGE_EN;
      end else if (mass_erase_go) begin
        state_q <= FS_MASS_EN;
      end else if (cmd == `CMD_UNLOCK1 && state_q == FS_LOCKED) begin
        state_q <= FS_UNLK1;
      end else if (cmd == `CMD_UNLOCK2 && state_q == FS_UNLK1) begin
        state_q <= FS_UNLOCKED;
      end else begin
        state_q <= FS_LOCKED;
      end
    end
  end

  // Protect register is mapped in only after command 5EH
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prot_sel_q <= 1'b0;
    end else if (fctl_wr) begin
      prot_sel_q <= (cmd == `CMD_PROT_SEL);
    end
  end

  // Page select register shares FF9H when protect is not mapped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      page_sel_q <= `PAGE_SEL_RESET;
    end else if (fprot_wr && !prot_sel_q) begin
      page_sel_q <= reg_req.wdata;
    end
  end

  sector_protect_reg u_prot (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .we(fprot_wr && prot_sel_q),
    .wdata(reg_req.wdata),
    .prot(prot)
  );

  // Arbitration: debugger first, constant stores otherwise
  prog_req_t req;
  logic req_take;
  logic prog_ok;
  logic prog_go;
  logic [`FLASH_AW-1:0] req_addr;
  assign dbg_ready = loaded_q && !busy_q;
  assign cpu_ready = loaded_q && !busy_q && !dbg_req.valid;
  assign req = dbg_req.valid ? dbg_req : cpu_req;
  assign req_take = clk_en && req.valid && loaded_q && !busy_q;
  assign req_addr = req.addr[`FLASH_AW-1:0];
  assign prog_ok = (req.addr[`OOR_MSB:`OOR_LSB] == `OOR_NONE) &&
                   !opt_q.prog_protect &&
                   !page_locked(prot, page_of(req_addr)) &&
                   ((state_q == FS_MASS_EN) ||
                    ((state_q == FS_PAGE_EN) &&
                     (page_of(req_addr) == sel_page)));
  assign prog_go = req_take && prog_ok;

  // Busy timer covers byte program and erase times
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      timer_q <= `TIMER_ZERO;
    end else if (clk_en) begin
      if (prog_go) begin
        busy_q <= 1'b1;
        timer_q <= `TIMER_W'(`PROG_CYCLES);
      end else if (page_erase_go || mass_erase_go) begin
        busy_q <= 1'b1;
        timer_q <= `TIMER_W'(ERASE_CYCLES);
      end else if (busy_q) begin
        timer_q <= timer_q - `TIMER_W'(1);
        busy_q <= (timer_q > `TIMER_W'(1));
      end
    end
  end

  // The core stalls and debugger requests wait; this clock and the peripherals keep going
  assign cpu_stall = busy_q;

  // Option loader reads the two option bytes after every reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ld_q <= LD_OPT0;
    end else if (clk_en) begin
      case (ld_q)
        LD_OPT0: ld_q <= LD_OPT1;
        LD_OPT1: ld_q <= LD_LAST;
        LD_LAST: ld_q <= LD_DONE;
        LD_DONE: ld_q <= LD_DONE;
        default: ld_q <= LD_OPT0;
      endcase
    end
  end

  always_comb begin
    case (ld_q)
      LD_OPT0: mem_rd_addr = `OPT_ADDR0;
      LD_OPT1: mem_rd_addr = `OPT_ADDR1;
      default: mem_rd_addr = fetch_addr;
    endcase
  end

  // Option registers are written only here, never from the bus
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opt_q <= '0;
      loaded_q <= 1'b0;
    end else if (clk_en) begin
      if (ld_q == LD_OPT1) begin
        opt_q.wdt_irq_mode <= mem_rdata[`OPT_WDT_IRQ];
        opt_q.wdt_always_on <= mem_rdata[`OPT_WDT_AO];
        opt_q.osc_mode <= mem_rdata[`OPT_OSC_MSB:`OPT_OSC_LSB];
        opt_q.vbo_stop_on <= mem_rdata[`OPT_VBO_STOP];
        opt_q.read_protect <= mem_rdata[`OPT_RD_PROT];
        opt_q.prog_protect <= mem_rdata[`OPT_PRG_PROT];
      end
      if (ld_q == LD_LAST) begin
        loaded_q <= 1'b1;
      end
    end
  end

  assign opt_cfg = opt_q;
  assign cpu_hold = !loaded_q;

  flash_array u_array (
    .clk(clk),
    .clk_en(clk_en),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rdata),
    .prog(prog_go),
    .prog_addr(req_addr),
    .prog_data(req.data),
    .erase_page(page_erase_go),
    .erase_all(mass_erase_go),
    .erase_idx(sel_page)
  );

  assign fetch_data = mem_rdata;

  // Register reads: status at FF8H, protect or page select at FF9H
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= `BYTE_ZERO;
      hit_q <= 1'b0;
    end else if (clk_en) begin
      hit_q <= 1'b0;
      rdata_q <= `BYTE_ZERO;
      if (reg_req.rd && reg_req.addr == `FCTL_ADDR) begin
        hit_q <= 1'b1;
        rdata_q[`ST_UNLOCKED] <= unlocked;
        rdata_q[`ST_PAGE_EN] <= (state_q == FS_PAGE_EN);
        rdata_q[`ST_MASS_EN] <= (state_q == FS_MASS_EN);
        rdata_q[`ST_BUSY] <= busy_q;
        rdata_q[`ST_PROT_SEL] <= prot_sel_q;
      end else if (reg_req.rd && reg_req.addr == `FPROT_ADDR) begin
        hit_q <= 1'b1;
        rdata_q <= prot_sel_q ? prot : page_sel_q;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit = hit_q;

  a_sel_on_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    (fctl_wr && cmd == `CMD_PROT_SEL) |=> prot_sel_q)
    else $error("protect register not mapped after select command");

  a_sel_off_other: assert property (@(posedge clk) disable iff (sys_rst)
    (fctl_wr && cmd != `CMD_PROT_SEL) |=> !prot_sel_q)
    else $error("page select not restored");

  a_reset_cmd_lock: assert property (@(posedge clk) disable iff (sys_rst)
    (fctl_wr && cmd == `CMD_RESET) |=> (state_q == FS_LOCKED && !prot_sel_q))
    else $error("reset command did not reset controller");

  a_prot_refuse: assert property (@(posedge clk) disable iff (sys_rst)
    prog_go |-> !prot[page_of(req_addr)])
    else $error("program reached protected sector");

  a_page_bound: assert property (@(posedge clk) disable iff (sys_rst)
    prog_go |-> (state_q == FS_MASS_EN ||
                 (state_q == FS_PAGE_EN && page_of(req_addr) == sel_page)))
    else $error("program outside enabled area");

  a_stall_prog: assert property (@(posedge clk) disable iff (sys_rst)
    prog_go |=> cpu_stall [*8])
    else $error("core not stalled during byte program");

  a_relock_other: assert property (@(posedge clk) disable iff (sys_rst)
    (fctl_wr && !page_erase_go && !mass_erase_go &&
     cmd != `CMD_UNLOCK1 && cmd != `CMD_UNLOCK2) |=> (state_q == FS_LOCKED))
    else $error("controller not relocked");

  a_hold_until_load: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(loaded_q) |-> ($past(ld_q) == LD_LAST && $past(cpu_hold)))
    else $error("core released before options loaded");

  a_opt_stable: assert property (@(posedge clk) disable iff (sys_rst)
    loaded_q |=> $stable(opt_q))
    else $error("options changed without reset");

endmodule

// *** pkg/flash_ctrl_map.svh ***
// Register addresses, command codes, field positions and timing counts
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH

// Register file addresses of the controller
`define FCTL_ADDR 12'hFF8
`define FPROT_ADDR 12'hFF9

// Flash control command codes
`define CMD_RESET 8'h00
`define CMD_PROT_SEL 8'h5E
`define CMD_UNLOCK1 8'h73
`define CMD_UNLOCK2 8'h8C
`define CMD_PAGE_ERASE 8'h95
`define CMD_MASS_ERASE 8'h63

// Reset and erased values
`define ERASED_BYTE 8'hFF
`define PROT_RESET 8'h00
`define PAGE_SEL_RESET 8'h00
`define BYTE_ZERO 8'h00

// Flash geometry: 2 KB in eight 256-byte pages, one protect bit each
`define FLASH_AW 11
`define FLASH_DEPTH 2048
`define PAGE_MSB 10
`define PAGE_LSB 8
`define OOR_MSB 15
`define OOR_LSB 11
`define OOR_NONE 5'h00

// Option bytes in program memory
`define OPT_ADDR0 11'h000
`define OPT_ADDR1 11'h001

// Option byte 0 field positions
`define OPT_WDT_IRQ 7
`define OPT_WDT_AO 6
`define OPT_OSC_MSB 5
`define OPT_OSC_LSB 4
`define OPT_VBO_STOP 3
`define OPT_RD_PROT 2
`define OPT_PRG_PROT 0

// Status byte field positions
`define ST_UNLOCKED 0
`define ST_PAGE_EN 1
`define ST_MASS_EN 2
`define ST_BUSY 3
`define ST_PROT_SEL 4

// Timing
`define CLK_PERIOD_NS 100
`define PROG_TIME_NS 20000
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_TIME_MS 50
`define ERASE_CYCLES_DEF (`ERASE_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define TIMER_W 20
`define TIMER_ZERO 20'h00000

`endif

// *** pkg/flash_ctrl_pkg.sv ***
// Types shared by the flash program and protect controller
package flash_ctrl_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } prog_req_t;

  typedef struct packed {
    logic wdt_irq_mode;
    logic wdt_always_on;
    logic read_protect;
    logic prog_protect;
    logic vbo_stop_on;
    logic [1:0] osc_mode;
  } opt_cfg_t;

  typedef enum logic [2:0] {
    FS_LOCKED,
    FS_UNLK1,
    FS_UNLOCKED,
    FS_PAGE_EN,
    FS_MASS_EN
  } fstate_t;

  typedef enum logic [1:0] {
    LD_OPT0,
    LD_OPT1,
    LD_LAST,
    LD_DONE
  } ldstate_t;

endpackage

// *** logic/sector_protect_reg.sv ***
// Set-only sector protect register
`include "flash_ctrl_map.svh"
module sector_protect_reg
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] prot
);

  logic [7:0] prot_q;

  // Writes only OR new ones in; reset leaves every sector open
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prot_q <= `PROT_RESET;
    end else if (clk_en && we) begin
      prot_q <= prot_q | wdata;
    end
  end

  assign prot = prot_q;

  a_prot_no_clear: assert property (@(posedge clk) disable iff (sys_rst)
    ((prot_q & $past(prot_q)) == $past(prot_q)))
    else $error("sector protect bit cleared");

  a_prot_reset_val: assert property (@(posedge clk)
    sys_rst |=> (prot_q == `PROT_RESET))
    else $error("sector protect not cleared by reset");

endmodule

// *** logic/flash_array.sv ***
// Flash byte array: program clears bits, erase sets page or all to ones
`include "flash_ctrl_map.svh"
module flash_array
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic clk_en,
  input wire logic [`FLASH_AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic prog,
  input wire logic [`FLASH_AW-1:0] prog_addr,
  input wire logic [7:0] prog_data,
  input wire logic erase_page,
  input wire logic erase_all,
  input wire logic [2:0] erase_idx
);

  // Two-state cells power up as zeros, so the option loader reads defined
  // bytes before the first erase instead of blocking erase on unknowns
  bit [7:0] mem [0:`FLASH_DEPTH-1];
  logic [7:0] rd_data_q;

  // Program ANDs the new byte in, so a bit only ever falls to zero
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (erase_all || erase_page) begin
        for (int i = 0; i < `FLASH_DEPTH; i++) begin
          if (erase_all || (i[`PAGE_MSB:`PAGE_LSB] == erase_idx)) begin
            mem[i] <= `ERASED_BYTE;
          end
        end
      end else if (prog) begin
        mem[prog_addr] <= mem[prog_addr] & prog_data;
      end
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    if (clk_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_q;

endmodule

// *** testbench/flash_requester.sv ***
// Model of the core and debugger issuing flash program requests
module flash_requester
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic cpu_ready,
  input wire logic dbg_ready,
  output prog_req_t cpu_req,
  output prog_req_t dbg_req,
  output logic lost
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle with no request pending
  initial begin
    cpu_req = '0;
    dbg_req = '0;
    lost = 1'b0;
  end

  // Hold the request until ready at an edge, then drop it with lines inverted
  task automatic send(input logic dbg, input logic [15:0] a,
                      input logic [7:0] d);
    prog_req_t r;
    int n;
    @(posedge clk);
    #1;
    r = '{valid: 1'b1, addr: a, data: d};
    n = 0;
    if (dbg) dbg_req = r;
    else cpu_req = r;
    while (!(dbg ? dbg_ready : cpu_ready) && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 500) lost = 1'b1;
    @(posedge clk);
    #1;
    r = '{valid: 1'b0, addr: ~a, data: ~d};
    if (dbg) dbg_req = r;
    else cpu_req = r;
  endtask
endmodule

// *** testbench/flash_program_protect_ctrl_tb.sv ***
// Self-checking bench for the flash program and protect controller
`include "flash_ctrl_map.svh"
module flash_program_protect_ctrl_tb
  import flash_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ERASE_N = 20;
  localparam int PROG_N = 200;
  logic clk;
  logic sys_rst;
  logic clk_en;
  reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_hit;
  prog_req_t cpu_req;
  prog_req_t dbg_req;
  logic cpu_ready;
  logic dbg_ready;
  logic [10:0] fetch_addr;
  logic [7:0] fetch_data;
  logic cpu_stall;
  logic cpu_hold;
  opt_cfg_t opt_cfg;
  logic req_lost;
  logic [7:0] rnd;
  logic [7:0] ob;
  logic [7:0] d1;
  int errors;
  int check_count;

  flash_program_protect_ctrl #(.ERASE_CYCLES(ERASE_N)) dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .cpu_req(cpu_req),
    .cpu_ready(cpu_ready), .dbg_req(dbg_req), .dbg_ready(dbg_ready),
    .fetch_addr(fetch_addr), .fetch_data(fetch_data),
    .cpu_stall(cpu_stall), .cpu_hold(cpu_hold), .opt_cfg(opt_cfg)
  );

  flash_requester host (
    .clk(clk), .cpu_ready(cpu_ready), .dbg_ready(dbg_ready),
    .cpu_req(cpu_req), .dbg_req(dbg_req), .lost(req_lost)
  );

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Option byte fields as the configuration should show them
  function automatic opt_cfg_t exp_opt(input logic [7:0] b);
    opt_cfg_t o;
    o.wdt_irq_mode = b[7];
    o.wdt_always_on = b[6];
    o.osc_mode = b[5:4];
    o.vbo_stop_on = b[3];
    o.read_protect = b[2];
    o.prog_protect = b[0];
    return o;
  endfunction

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    reg_req.wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] m,
                        input logic [7:0] e, input logic h, input string s);
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1;
    reg_req.rd = 1'b0;
    check(reg_hit === h && (reg_rdata & m) === e, s);
  endtask

  // Count the cycles the core is stalled, bounded
  task automatic stall_chk(input int n, input string s);
    int c;
    c = 0;
    while (cpu_stall === 1'b1 && c < 1000) begin
      @(posedge clk);
      #1;
      c++;
    end
    check(c == n, s);
  endtask

  task automatic fetch_chk(input logic [10:0] a, input logic [7:0] e,
                           input string s);
    @(posedge clk);
    #1;
    fetch_addr = a;
    @(posedge clk);
    #1;
    check(fetch_data === e, s);
  endtask

  task automatic do_reset();
    int n;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check(cpu_hold === 1'b1 && opt_cfg === '0, "reset state");
    sys_rst = 1'b0;
    n = 0;
    while (cpu_hold !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n == 3, "option load length");
  endtask

  // Callers never program one byte more than twice between erases
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_req = '0;
    fetch_addr = '0;
    errors = 0;
    check_count = 0;
    rnd = 8'h27;
    do_reset();
    reg_wr(`FCTL_ADDR, `CMD_UNLOCK1);
    reg_wr(`FCTL_ADDR, `CMD_UNLOCK2);
    reg_wr(`FCTL_ADDR, `CMD_MASS_ERASE);
    stall_chk(ERASE_N, "mass erase busy");
    reg_rd(`FCTL_ADDR, 8'h07, 8'h05, 1'b1, "mass enabled");
    rnd = lfsr(rnd);
    ob = rnd & 8'hFA;
    host.send(1'b1, 16'h0000, ob);
    check(dbg_ready === 1'b0 && cpu_ready === 1'b0, "busy ready");
    stall_chk(PROG_N, "option byte program");
    check(dbg_ready === 1'b1 && cpu_ready === 1'b1, "idle ready");
    host.send(1'b0, 16'h0105, rnd);
    stall_chk(PROG_N, "page one program");
    d1 = lfsr(rnd);
    host.send(1'b0, 16'h07FF, d1);
    stall_chk(PROG_N, "top byte program");
    fetch_chk(11'h7FF, d1, "top byte value");
    host.send(1'b1, 16'h0800, 8'h00);
    stall_chk(0, "out of range accepted");
    check(opt_cfg !== exp_opt(ob), "options moved early");
    do_reset();
    check(opt_cfg === exp_opt(ob), "options after reset");
    reg_rd(12'hFF7, 8'hFF, 8'h00, 1'b0, "unmapped hit");
    reg_wr(`FCTL_ADDR, `CMD_RESET);
    reg_wr(`FCTL_ADDR, `CMD_PROT_SEL);
    reg_rd(`FPROT_ADDR, 8'hFF, 8'h00, 1'b1, "protect reset");
    reg_rd(`FCTL_ADDR, 8'h10, 8'h10, 1'b1, "protect mapped");
    reg_wr(`FPROT_ADDR, 8'h04);
    reg_wr(`FPROT_ADDR, 8'h01);
    reg_rd(`FPROT_ADDR, 8'hFF, 8'h05, 1'b1, "protect set only");
    reg_wr(`FCTL_ADDR, `CMD_RESET);
    reg_rd(`FCTL_ADDR, 8'h1F, 8'h00, 1'b1, "controller state");
    reg_wr(`FPROT_ADDR, 8'h01);
    reg_wr(`FCTL_ADDR, `CMD_UNLOCK1);
    reg_wr(`FCTL_ADDR, `CMD_UNLOCK2);
    reg_wr(`FCTL_ADDR, `CMD_PAGE_ERASE);
    stall_chk(ERASE_N, "page erase busy");
    reg_rd(`FCTL_ADDR, 8'h07, 8'h03, 1'b1, "page enabled");
    fetch_chk(11'h105, `ERASED_BYTE, "page not erased");
    fetch_chk(11'h7FF, d1, "other page erased");
    rnd = lfsr(d1);
    d1 = lfsr(rnd);
    host.send(1'b1, 16'h0105, rnd);
    stall_chk(PROG_N, "program stall");
    host.send(1'b0, 16'h0105, d1);
    stall_chk(PROG_N, "second program");
    fetch_chk(11'h105, rnd & d1, "bits only cleared");
    host.send(1'b1, 16'h0205, 8'h00);
    stall_chk(0, "outside page accepted");
    fetch_chk(11'h205, `ERASED_BYTE, "outside page changed");
    reg_wr(`FCTL_ADDR, `CMD_RESET);
    host.send(1'b0, 16'h0106, 8'h00);
    stall_chk(0, "locked accepted");
    fetch_chk(11'h106, `ERASED_BYTE, "locked changed");
    reg_wr(`FPROT_ADDR, 8'h02);
    reg_wr(`FCTL_ADDR, `CMD_UNLOCK1);
    reg_wr(`FCTL_ADDR, `CMD_UNLOCK2);
    reg_wr(`FCTL_ADDR, `CMD_PAGE_ERASE);
    stall_chk(0, "protected erase");
    reg_rd(`FCTL_ADDR, 8'h07, 8'h00, 1'b1, "protected not locked");
    // A write while the clock enable is low must not land
    clk_en = 1'b0;
    reg_wr(`FPROT_ADDR, 8'h06);
    clk_en = 1'b1;
    reg_rd(`FPROT_ADDR, 8'hFF, 8'h02, 1'b1, "frozen write landed");
    check(req_lost === 1'b0, "request never taken");
    tally_and_finish();
  end
endmodule
